// ===== rtl/tws_master_regs.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module tws_master_regs
    import tws_pkg::*;
(
    input  wire logic           I_REF_CLK,
    input  wire logic           I_RST_N,
    input  wire logic           I_PSEL,
    input  wire logic           I_PENABLE,
    input  wire logic           I_PWRITE,
    input  wire logic [7:0]     I_PADDR,
    input  wire logic [31:0]    I_PWDATA,
    output logic [31:0]         O_PRDATA,
    output logic                O_PREADY,
    output logic                O_PSLVERR,
    input  wire tws_seq_evt_t   I_SEQ_EVT,
    input  wire logic [1:0]     I_IADDR_IDX,
    input  wire logic           I_SCL_RUN,
    output tws_frame_cfg_t      O_FRAME_CFG,
    output logic [7:0]          O_ADDR_BYTE,
    output logic [7:0]          O_IADDR_BYTE,
    output logic [7:0]          O_TX_DATA,
    output logic                O_TX_TAKE,
    output logic                O_FORCE_STOP,
    output logic                O_START_CMD,
    output logic                O_STOP_CMD,
    output logic                O_MASTER_EN,
    output logic                O_SCL_LEVEL,
    output logic                O_SCL_EDGE,
    output logic                O_IRQ
);

    // block overview, for whoever picks this up next:
    // this module is the software-facing half of the two-wire master.
    // it owns the mode, internal address, clock waveform, status,
    // interrupt enable and the two holding registers.
    // the byte sequencer that walks start, address, data and stop
    // lives outside; it talks to us through I_SEQ_EVT and I_IADDR_IDX
    // and reads back the frame configuration, address bytes, holding byte and command pulses.
    //
    // timing summary:
    // - apb has zero wait states; pready is tied high
    // - read data is captured in the setup cycle, so a flag that
    //   sets during the access cycle shows on the next read
    // - command bits (start, stop) leave as one-cycle pulses the
    //   cycle after the control write commits
    // - sequencer events act on the edge where they are high
    // - take and forced-stop pulses follow one cycle later
    //
    // status flag policy:
    // - every hardware set beats any clear in the same cycle,
    //   so an event in the access cycle never gets lost behind that access
    // - the interrupt clear register only drops the bits named
    //   in its write data
    // - overrun and underrun clear on a status read only once done is up,
    //   so polling in mid-frame cannot hide an error
    //
    // limitations:
    // - no software reset command; only I_RST_N clears state
    // - the waveform registers are not shadowed; rewriting them
    //   while the serial clock runs bends the current phase
    // - the interrupt line is a level and needs no acknowledge

    // registers
    logic [31:0] mode_reg;
    logic [31:0] iaddr_reg;
    logic [31:0] clkwave_reg;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] irq_en_reg;
    logic [7:0]  rx_hold_reg;
    logic [7:0]  tx_hold_reg;
    logic        master_en_reg;
    logic        start_reg;
    logic        stop_reg;
    logic        take_reg;
    logic        force_stop_reg;
    logic [15:0] phase_cnt_reg;
    logic        scl_reg;
    logic        edge_reg;

    // address decode notes:
    // - only exact byte addresses hit; a misaligned or unused
    //   address falls through to the error response
    // - status and receive holding are read-only; writes there
    //   hit a mapped address, so they are quietly dropped
    // - the control register reads as zero, being command-only
    // - keeping all decode as named wires lets the flag logic
    //   below read like the behaviour it implements

    // apb decode: access phase commits in its only cycle
    wire         acc      = I_PSEL & I_PENABLE;
    wire         wr_acc   = acc & I_PWRITE;
    wire         rd_acc   = acc & ~I_PWRITE;
    wire         hit_ctl  = (I_PADDR == OFS_CONTROL);
    wire         hit_mode = (I_PADDR == OFS_MODE);
    wire         hit_internal_addr_bytes = (I_PADDR == OFS_IADDR);
    wire         hit_cw   = (I_PADDR == OFS_CLKWAVE);
    wire         hit_st   = (I_PADDR == OFS_STATUS);
    wire         hit_ien  = (I_PADDR == OFS_IRQ_EN);
    wire         hit_iclr = (I_PADDR == OFS_IRQ_CLR);
    wire         hit_rx   = (I_PADDR == OFS_RX_HOLD);
    wire         hit_tx   = (I_PADDR == OFS_TX_HOLD);
    wire         mapped   = hit_ctl | hit_mode | hit_internal_addr_bytes | hit_cw |
                            hit_st | hit_ien | hit_iclr | hit_rx | hit_tx;

    wire         ctl_wr   = wr_acc & hit_ctl;
    wire         master_enable_cmd_cmd = ctl_wr & I_PWDATA[CTL_MASTER_ENABLE_CMD_BIT]
                            & ~I_PWDATA[CTL_MSDIS_BIT];
    wire         msdis    = ctl_wr & I_PWDATA[CTL_MSDIS_BIT];
    wire         tx_wr    = wr_acc & hit_tx;
    wire         st_rd    = rd_acc & hit_st;
    wire         rx_rd    = rd_acc & hit_rx;
    wire         iclr_wr  = wr_acc & hit_iclr;

    // zero wait states; unmapped addresses answer with an error
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = acc & ~mapped;

    // read mux; reserved bits are masked off
    // reserved bits zero
    wire [31:0] rd_data =
        hit_mode ? (mode_reg & MODE_MASK) :
        hit_internal_addr_bytes ? (iaddr_reg & IADDR_MASK) :
        hit_cw   ? (clkwave_reg & CLKWAVE_MASK) :
        hit_st   ? (status_reg & STATUS_MASK) :
        hit_ien  ? (irq_en_reg & STATUS_MASK) :
        hit_rx   ? {24'h00_0000, rx_hold_reg} :
        hit_tx   ? {24'h00_0000, tx_hold_reg} : 32'h0000_0000;

    // prdata registered at setup so it is steady in the access phase
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PRDATA <= REG_RESET;
        end else if (I_PSEL & ~I_PENABLE) begin
            O_PRDATA <= rd_data;
        end
    end

    // configuration registers, masked on write
    // writes to reserved ignored
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mode_reg    <= REG_RESET;
            iaddr_reg   <= REG_RESET;
            clkwave_reg <= REG_RESET;
            irq_en_reg  <= REG_RESET;
        end else if (wr_acc) begin
            if (hit_mode) mode_reg <= I_PWDATA & MODE_MASK;
            if (hit_internal_addr_bytes) iaddr_reg <= I_PWDATA & IADDR_MASK;
            if (hit_cw)   clkwave_reg <= I_PWDATA & CLKWAVE_MASK;
            if (hit_ien)  irq_en_reg <= I_PWDATA & STATUS_MASK;
        end
    end

    // frame configuration fields
    // device address field
    assign O_FRAME_CFG.target_device_addr =
        mode_reg[MODE_DEV_LSB +: 7];
    assign O_FRAME_CFG.read_direction = mode_reg[MODE_READ_BIT];
    assign O_FRAME_CFG.internal_addr_size =
        mode_reg[MODE_SIZE_LSB +: 2];
    assign O_FRAME_CFG.internal_addr_bytes = iaddr_reg[23:0];

    assign O_ADDR_BYTE = {mode_reg[MODE_DEV_LSB +: 7],
                          mode_reg[MODE_READ_BIT]};

    // sequencer walks index from size-1 down to 0, high byte first;
    // in ten-bit mode byte 0 is the low slave address byte
    // select address byte
    wire [1:0] iaddr_size = mode_reg[MODE_SIZE_LSB +: 2];
    wire       idx_ok     = (I_IADDR_IDX < iaddr_size);
    assign O_IADDR_BYTE = !idx_ok ? 8'h00 :
        (I_IADDR_IDX == 2'd2) ? iaddr_reg[23:16] :
        (I_IADDR_IDX == 2'd1) ? iaddr_reg[15:8] : iaddr_reg[7:0];

    // start and stop commands become one-cycle pulses; the enable level is held
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            master_en_reg <= 1'b0;
            start_reg     <= 1'b0;
            stop_reg      <= 1'b0;
        end else begin
            start_reg <= ctl_wr & I_PWDATA[CTL_START_BIT];
            stop_reg  <= ctl_wr & I_PWDATA[CTL_STOP_BIT];
            if (msdis) begin
                master_en_reg <= 1'b0;
            end else if (master_enable_cmd_cmd) begin
                master_en_reg <= 1'b1;
            end
        end
    end
    assign O_START_CMD = start_reg;
    assign O_STOP_CMD  = stop_reg;
    assign O_MASTER_EN = master_en_reg;

    // shifter request: load from holding or report starvation
    wire tx_empty  = status_reg[ST_TXEMPTY_BIT];
    wire load_ok   = I_SEQ_EVT.shift_load_req & ~tx_empty;
    wire starve    = I_SEQ_EVT.shift_load_req & tx_empty;
    wire overrun   = I_SEQ_EVT.rx_valid & status_reg[ST_RXFULL_BIT]
                     & ~rx_rd;
    wire done_evt  = I_SEQ_EVT.stop_sent & I_SEQ_EVT.shift_empty
                     & tx_empty;

    // holding register handshake notes:
    // - a load request with a byte waiting turns into a take
    //   pulse next cycle; the byte itself sits on O_TX_DATA
    // - a load request with nothing waiting is a starvation:
    //   the sequencer gets a forced stop pulse instead
    // - received bytes overwrite the holding register at once;
    //   an unread byte is lost, and overrun records that
    // - the tx holding byte stays readable, which helps software
    //   that wants to see what is queued

    // holding registers and shifter handshake
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_hold_reg    <= 8'h00;
            rx_hold_reg    <= 8'h00;
            take_reg       <= 1'b0;
            force_stop_reg <= 1'b0;
        end else begin
            take_reg       <= load_ok;
            force_stop_reg <= starve;
            if (tx_wr) tx_hold_reg <= I_PWDATA[7:0];
            if (I_SEQ_EVT.rx_valid) rx_hold_reg <= I_SEQ_EVT.rx_data;
        end
    end
    assign O_TX_DATA    = tx_hold_reg;
    assign O_TX_TAKE    = take_reg;
    assign O_FORCE_STOP = force_stop_reg;

    // status update order matters: clears are applied first,
    // then sets, so a set in the same cycle always wins.
    // done falls at frame start and rises on a finished stop,
    // on the enable command, or on a missing acknowledge.
    // the tx empty flag also rises with the enable command, so
    // software sees a free holding register right after enable.
    // no-ack clears on any status read; overrun and underrun
    // wait for a read taken with done already set.
    // the final mask keeps reserved positions at zero whatever
    // the clear register was fed.

    // status next value; every hardware set beats its clear
    always_comb begin
        status_next = status_reg;
        // software clear register drops named bits
        if (iclr_wr) status_next = status_next & ~I_PWDATA;
        if (I_SEQ_EVT.frame_start) status_next[ST_DONE_BIT] = 1'b0;
        if (rx_rd) status_next[ST_RXFULL_BIT] = 1'b0;
        if (tx_wr) status_next[ST_TXEMPTY_BIT] = 1'b0;
        if (st_rd && status_reg[ST_DONE_BIT]) begin
            status_next[ST_OVR_BIT] = 1'b0;
            status_next[ST_UNR_BIT] = 1'b0;
        end
        if (st_rd) status_next[ST_NO_ACK_FLAG_BIT] = 1'b0;
        if (done_evt || master_enable_cmd_cmd) status_next[ST_DONE_BIT] = 1'b1;
        if (I_SEQ_EVT.rx_valid) status_next[ST_RXFULL_BIT] = 1'b1;
        if (load_ok || master_enable_cmd_cmd) status_next[ST_TXEMPTY_BIT] = 1'b1;
        if (overrun) status_next[ST_OVR_BIT] = 1'b1;
        if (starve) status_next[ST_UNR_BIT] = 1'b1;
        if (I_SEQ_EVT.ack_missing) begin
            status_next[ST_NO_ACK_FLAG_BIT]    = 1'b1;
            status_next[ST_DONE_BIT]    = 1'b1;
            status_next[ST_TXEMPTY_BIT] = 1'b1;
        end
        status_next = status_next & STATUS_MASK;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            status_reg <= REG_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // level interrupt while any enabled flag stands
    assign O_IRQ = |(status_reg & irq_en_reg);

    // serial clock phase lengths, up to 255 << 7 plus three
    wire [2:0]  exp_div  = clkwave_reg[CW_EXP_LSB +: 3];
    wire [15:0] low_len  = (16'(clkwave_reg[7:0]) << exp_div)
                           + PHASE_EXTRA;
    wire [15:0] high_len = (16'(clkwave_reg[CW_HIGH_LSB +: 8])
                           << exp_div) + PHASE_EXTRA;
    wire [15:0] cur_len  = scl_reg ? high_len : low_len;
    // greater-or-equal so a shortened phase cannot overshoot
    wire        phase_end = (phase_cnt_reg >= cur_len - 16'd1);

    // serial clock generator notes:
    // - each phase lasts its divider shifted by the exponent,
    //   plus three reference cycles of fixed overhead
    // - the counter runs from zero to length minus one, then
    //   the level toggles and the edge pulse fires once
    // - dropping I_SCL_RUN parks the line high, its idle level,
    //   so the bus sees no stray edge between frames
    // - the level is a flip-flop, not a gated clock, so it is
    //   glitch-free towards the pad logic
    // - the widest phase fits sixteen bits with room to spare

    // clock generator idles high; a run starts with a high phase
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            phase_cnt_reg <= 16'h0000;
            scl_reg       <= 1'b1;
            edge_reg      <= 1'b0;
        end else if (!I_SCL_RUN) begin
            phase_cnt_reg <= 16'h0000;
            scl_reg       <= 1'b1;
            edge_reg      <= 1'b0;
        end else if (phase_end) begin
            phase_cnt_reg <= 16'h0000;
            scl_reg       <= ~scl_reg;
            edge_reg      <= 1'b1;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 16'd1;
            edge_reg      <= 1'b0;
        end
    end
    assign O_SCL_LEVEL = scl_reg;
    assign O_SCL_EDGE  = edge_reg;

endmodule : tws_master_regs

// ===== rtl/tws_pkg.sv
// Notes on behaviour
// - address size picks zero to three address bytes
// - bit 12 chooses write (0) or read (1)
// - bits 22..16 hold the target device address
// - internal address bytes sent per size count
// - ten-bit mode uses low address byte here
// - low phase is low divider shifted plus three
// - high phase is high divider shifted plus three
// - done flag low during the current frame
// - done set after stop, empty buffers, or enable
// - rx full set while unread byte waits
// - tx holding write clears tx empty flag
// - tx empty set on shifter load or missing ack
// - master enable command sets tx empty
// - overrun on reload while full, status read with done set clears
// - underrun when shifter starves, forces stop
// - no-ack with done, cleared by status read
// - address byte is seven bits then direction
// - reading rx holding clears rx full flag
package tws_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_MODE      = 8'h04;
    localparam logic [7:0] OFS_IADDR     = 8'h0C;
    localparam logic [7:0] OFS_CLKWAVE   = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h28;
    localparam logic [7:0] OFS_RX_HOLD   = 8'h30;
    localparam logic [7:0] OFS_TX_HOLD   = 8'h34;

    // writable bits of each register
    localparam logic [31:0] MODE_MASK    = 32'h007F_1300;
    localparam logic [31:0] IADDR_MASK   = 32'h00FF_FFFF;
    localparam logic [31:0] CLKWAVE_MASK = 32'h0007_FFFF;
    localparam logic [31:0] STATUS_MASK  = 32'h0000_01C7;

    // field positions
    localparam int MODE_SIZE_LSB  = 8;
    localparam int MODE_READ_BIT  = 12;
    localparam int MODE_DEV_LSB   = 16;
    localparam int CW_HIGH_LSB    = 8;
    localparam int CW_EXP_LSB     = 16;
    localparam int CTL_START_BIT  = 0;
    localparam int CTL_STOP_BIT   = 1;
    localparam int CTL_MASTER_ENABLE_CMD_BIT   = 2;
    localparam int CTL_MSDIS_BIT  = 3;
    localparam int ST_DONE_BIT    = 0;
    localparam int ST_RXFULL_BIT  = 1;
    localparam int ST_TXEMPTY_BIT = 2;
    localparam int ST_OVR_BIT     = 6;
    localparam int ST_UNR_BIT     = 7;
    localparam int ST_NO_ACK_FLAG_BIT    = 8;

    // reset values and phase overhead
    localparam logic [31:0] REG_RESET    = 32'h0000_0000;
    localparam logic [15:0] PHASE_EXTRA  = 16'h0003;

    // configuration handed to the byte sequencer
    typedef struct packed {
        logic [6:0]  target_device_addr;
        logic        read_direction;
        logic [1:0]  internal_addr_size;
        logic [23:0] internal_addr_bytes;
    } tws_frame_cfg_t;

    // events reported by the byte sequencer
    typedef struct packed {
        logic       frame_start;
        logic       shift_load_req;
        logic       shift_empty;
        logic       stop_sent;
        logic       ack_missing;
        logic       rx_valid;
        logic [7:0] rx_data;
    } tws_seq_evt_t;
endpackage : tws_pkg

// ===== tb/tws_seq_model.sv
`timescale 1ns/1ps
// byte sequencer stand-in: one-cycle event pulses on demand
module tws_seq_model
    import tws_pkg::*;
(
    input  wire logic i_clk,
    output tws_seq_evt_t o_evt
);
    // shift_empty is a level, kept across pulses
    initial o_evt = '0;
    // kind: 0 frame start, 1 load req, 2 ack miss, 3 rx byte, 4 stop
    task automatic pulse(input int kind, input logic [7:0] data);
        @(posedge i_clk);
        o_evt.frame_start <= (kind == 0);
        o_evt.shift_load_req <= (kind == 1);
        o_evt.ack_missing <= (kind == 2);
        o_evt.rx_valid <= (kind == 3);
        o_evt.stop_sent <= (kind == 4);
        o_evt.rx_data <= data;
        @(posedge i_clk);
        o_evt <= '{shift_empty: o_evt.shift_empty, default: '0};
        #1;
    endtask : pulse
    // shifter-empty level, changed just after a clock edge
    task automatic set_empty(input logic v);
        @(posedge i_clk);
        o_evt.shift_empty <= v;
        #1;
    endtask : set_empty
endmodule : tws_seq_model

// ===== tb/tws_master_regs_sva.sv
`timescale 1ns/1ps
module tws_sva
    import tws_pkg::*;
(
    input wire logic I_REF_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA, O_PRDATA,
    input wire logic O_PSLVERR, O_TX_TAKE, O_FORCE_STOP,
    input wire tws_seq_evt_t I_SEQ_EVT,
    input wire logic [1:0] I_IADDR_IDX,
    input wire tws_frame_cfg_t O_FRAME_CFG,
    input wire logic [7:0] O_ADDR_BYTE, O_IADDR_BYTE,
    input wire logic O_MASTER_EN, O_SCL_LEVEL, O_SCL_EDGE
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    logic [31:0] wd_q;
    // write data one cycle back, to compare against mirrored fields
    always_ff @(posedge I_REF_CLK) wd_q <= I_PWDATA;
    // access decode
    wire acc = I_PSEL && I_PENABLE;
    wire mapped = I_PADDR inside {OFS_CONTROL, OFS_MODE, OFS_IADDR,
        OFS_CLKWAVE, OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR, OFS_RX_HOLD,
        OFS_TX_HOLD};
    wire wr = acc && I_PWRITE;
    wire [1:0] sz = O_FRAME_CFG.internal_addr_size;
    a_take_cause: assert property (
        O_TX_TAKE |-> $past(I_SEQ_EVT.shift_load_req))
        else $error("tx take without load request");
    a_stop_cause: assert property (
        O_FORCE_STOP |-> $past(I_SEQ_EVT.shift_load_req) && !O_TX_TAKE)
        else $error("forced stop without starved request");
    a_addr_byte: assert property (
        O_ADDR_BYTE == {O_FRAME_CFG.target_device_addr,
                        O_FRAME_CFG.read_direction})
        else $error("address byte wrong");
    a_iaddr_none: assert property (
        I_IADDR_IDX >= sz |-> O_IADDR_BYTE == 8'h00)
        else $error("address byte beyond size not zero");
    a_iaddr_pick: assert property (
        I_IADDR_IDX < sz |-> O_IADDR_BYTE ==
            O_FRAME_CFG.internal_addr_bytes[I_IADDR_IDX*8 +: 8])
        else $error("internal address byte wrong");
    a_unmapped_err: assert property (
        acc && !mapped |-> O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_enable_cmd: assert property (
        wr && I_PADDR == OFS_CONTROL && I_PWDATA[2] && !I_PWDATA[3]
        |=> O_MASTER_EN) else $error("enable command lost");
    a_mode_mirror: assert property (
        wr && I_PADDR == OFS_MODE |=>
        O_FRAME_CFG.target_device_addr == wd_q[22:16] &&
        O_FRAME_CFG.read_direction == wd_q[12] && sz == wd_q[9:8])
        else $error("mode fields not mirrored");
    a_scl_edge: assert property (
        $changed(O_SCL_LEVEL) |-> ##[0:1] O_SCL_EDGE)
        else $error("serial clock toggle without edge pulse");
    c_take: cover property (O_TX_TAKE);
    c_stop: cover property (O_FORCE_STOP);
    c_err: cover property (acc && !mapped);
endmodule : tws_sva
bind tws_master_regs tws_sva tws_sva_inst (.I_REF_CLK(I_REF_CLK),
    .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_TX_TAKE(O_TX_TAKE),
    .O_FORCE_STOP(O_FORCE_STOP), .I_SEQ_EVT(I_SEQ_EVT),
    .I_IADDR_IDX(I_IADDR_IDX), .O_FRAME_CFG(O_FRAME_CFG),
    .O_ADDR_BYTE(O_ADDR_BYTE), .O_IADDR_BYTE(O_IADDR_BYTE),
    .O_MASTER_EN(O_MASTER_EN), .O_SCL_LEVEL(O_SCL_LEVEL),
    .O_SCL_EDGE(O_SCL_EDGE));

// ===== tb/tb_tws_master_regs.sv
`timescale 1ns/1ps
module tb_tws_master_regs;
    import tws_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, run = 0;
    logic [7:0] paddr = '0, ab, ib, td;
    logic [31:0] pwd = '0, rd, prd;
    logic [1:0] idx = '0;
    logic rdy, err, rerr, take, fstop, stc, spc, men, irq, sedge;
    tws_seq_evt_t evt;
    tws_frame_cfg_t cfg;
    int mismatches = 0, compares = 0, t[3], k;
    logic [31:0] rows[5][3] = '{'{OFS_MODE, '1, MODE_MASK},
        '{OFS_IADDR, '1, IADDR_MASK}, '{OFS_CLKWAVE, '1, CLKWAVE_MASK},
        '{OFS_STATUS, '1, 32'h0000_0000},
        '{OFS_TX_HOLD, '1, 32'h0000_00FF}};
    // 20 MHz reference
    always #25 clk = ~clk;
    tws_seq_model tws_seq_model_inst (.i_clk(clk), .o_evt(evt));
    tws_master_regs tws_master_regs_inst (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .I_SEQ_EVT(evt), .I_IADDR_IDX(idx), .I_SCL_RUN(run),
        .O_FRAME_CFG(cfg), .O_ADDR_BYTE(ab), .O_IADDR_BYTE(ib),
        .O_TX_DATA(td), .O_TX_TAKE(take), .O_FORCE_STOP(fstop),
        .O_START_CMD(stc), .O_STOP_CMD(spc), .O_MASTER_EN(men),
        .O_SCL_LEVEL(), .O_SCL_EDGE(sedge), .O_IRQ(irq));
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches",
                 compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : chk
    // one APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        if (n == 20) begin
            mismatches++;
            close_out();
        end
        rd = prd;
        rerr = err;
        {psel, pen} <= 2'b00;
        #1;
    endtask : apb
    task automatic st(input logic [31:0] exp);
        apb(0, OFS_STATUS, 0);
        chk(rd, exp, "status");
    endtask : st
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        st(32'h0000_0000);
        foreach (rows[i]) begin
            apb(1, rows[i][0][7:0], rows[i][1]);
            apb(0, rows[i][0][7:0], 0);
            chk(rd, rows[i][2], "readback");
        end
        $display("register rows done");
        apb(0, 8'h08, 0);
        chk(rd, 32'h0000_0000, "unmapped data");
        chk(rerr, 1, "unmapped error");
        apb(1, OFS_MODE, 32'h0055_1200);
        apb(1, OFS_IADDR, 32'h00C3_B2A1);
        chk(ab, 8'hAB, "address byte");
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            idx <= k[1:0];
            @(negedge clk);
            chk(ib, k < 2 ? 8'hA1 + k * 8'h11 : 8'h00, "iaddr");
        end
        $display("frame config done");
        apb(1, OFS_CONTROL, 32'h0000_0007);
        chk({stc, spc, men}, 3'b111, "commands");
        st(32'h0000_0005);
        apb(1, OFS_TX_HOLD, 32'h0000_005A);
        st(32'h0000_0001);
        tws_seq_model_inst.pulse(0, 0);
        st(32'h0000_0000);
        tws_seq_model_inst.pulse(1, 0);
        chk({take, td}, 9'h15A, "shifter load");
        st(32'h0000_0004);
        tws_seq_model_inst.set_empty(1);
        tws_seq_model_inst.pulse(4, 0);
        st(32'h0000_0005);
        tws_seq_model_inst.pulse(0, 0);
        tws_seq_model_inst.pulse(3, 8'hA5);
        tws_seq_model_inst.pulse(3, 8'h3C);
        st(32'h0000_0046);
        apb(0, OFS_RX_HOLD, 0);
        chk(rd, 32'h0000_003C, "rx byte");
        st(32'h0000_0044);
        tws_seq_model_inst.pulse(1, 0);
        chk(fstop, 1, "starved stop");
        apb(1, OFS_IRQ_EN, 32'h0000_0100);
        chk(irq, 0, "irq masked");
        tws_seq_model_inst.pulse(2, 0);
        chk(irq, 1, "irq raised");
        st(32'h0000_01C5);
        st(32'h0000_0005);
        chk(irq, 0, "irq after read");
        apb(1, OFS_IRQ_EN, 32'h0000_0004);
        chk(irq, 1, "irq tx empty");
        apb(1, OFS_IRQ_CLR, 32'h0000_0004);
        chk(irq, 0, "irq cleared");
        $display("status flow done");
        // low 2, high 1, exponent 1: phases of 7 and 5 cycles
        apb(1, OFS_CLKWAVE, 32'h0001_0102);
        @(posedge clk);
        run <= 1;
        k = 0;
        for (int n = 0; n < 300 && k < 3; n++) begin
            @(posedge clk);
            if (sedge === 1'b1) t[k++] = n;
        end
        chk(k, 3, "edge count");
        chk(t[2] - t[0], 12, "clock period");
        chk((t[1] - t[0]) * (t[2] - t[1]), 35, "phase split");
        $display("serial clock done");
        // reset again in mid-run: flags and enable must drop
        @(posedge clk);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        chk(men, 0, "enable after reset");
        st(32'h0000_0000);
        $display("reset done");
        close_out();
    end
endmodule : tb_tws_master_regs
